// File: rtl/ddl_defs.svh
`ifndef DDL_DEFS_SVH
`define DDL_DEFS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define DDL_CLK_PERIOD_NS 50
`define DDL_FAST_SETTLE_NS 4000
`define DDL_SLOW_SETTLE_NS 12000
`define DDL_FAST_SETTLE_CYC ((`DDL_FAST_SETTLE_NS + `DDL_CLK_PERIOD_NS - 1) / `DDL_CLK_PERIOD_NS)
`define DDL_SLOW_SETTLE_CYC ((`DDL_SLOW_SETTLE_NS + `DDL_CLK_PERIOD_NS - 1) / `DDL_CLK_PERIOD_NS)

// ----------------------------------------
// serial word layout
// ----------------------------------------
`define DDL_WORD_BITS 16
`define DDL_CODE_BITS 12
`define DDL_BIT_LATCH_A 15
`define DDL_BIT_SPEED 14
`define DDL_BIT_POWER_DOWN 13
`define DDL_BIT_BUF_ONLY 12

// ----------------------------------------
// register map
// ----------------------------------------
`define DDL_OFF_CTRL 12'h000
`define DDL_OFF_LATCH_A 12'h004
`define DDL_OFF_LATCH_B 12'h008
`define DDL_OFF_DBUF 12'h00C
`define DDL_OFF_STATUS 12'h010
`define DDL_OFF_LAST_WORD 12'h014
`define DDL_CTRL_LINK_EN 0
`define DDL_CTRL_CLEAR 1
`define DDL_CTRL_RESET 1'b1
`define DDL_ST_FAST 0
`define DDL_ST_POWER_DOWN 1
`define DDL_ST_SETTLING 2
`define DDL_ST_ACTIVE 3
`define DDL_ST_DONE 4
`define DDL_ST_COUNT_LSB 8

`endif

// File: rtl/ddl_pkg.sv
package ddl_pkg;

  typedef struct packed {
    logic latch_a_sel;
    logic speed_fast;
    logic power_down;
    logic buffer_only;
    logic [11:0] code;
  } ddl_word_t;

  typedef struct packed {
    logic [11:0] code_a;
    logic [11:0] code_b;
  } ddl_codes_t;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_SHIFT = 2'b01,
    LINK_DONE = 2'b11
  } ddl_link_state_t;

endpackage

// File: rtl/ddl_top.sv
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ddl_defs.svh"

module ddl_top
  import ddl_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  output var ddl_codes_t dac_codes,
  output var logic fast_settle,
  output var logic power_down,
  output var logic settling,
  output var logic update_pulse
);

  localparam logic [4:0] WORD_BITS = 5'(`DDL_WORD_BITS);
  localparam logic [7:0] FAST_CYC = 8'(`DDL_FAST_SETTLE_CYC);
  localparam logic [7:0] SLOW_CYC = 8'(`DDL_SLOW_SETTLE_CYC);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] cs_sync_q;
  logic [1:0] sclk_sync_q;
  logic [1:0] sdi_sync_q;
  logic cs_prev_q;
  logic sclk_prev_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cs_sync_q <= 2'h3;
      sclk_sync_q <= 2'h3;
      sdi_sync_q <= 2'h0;
      cs_prev_q <= 1'b1;
      sclk_prev_q <= 1'b1;
    end
    else if (clk_en)
    begin
      cs_sync_q <= {cs_sync_q[0], chip_select_n};
      sclk_sync_q <= {sclk_sync_q[0], serial_clock};
      sdi_sync_q <= {sdi_sync_q[0], serial_data_in};
      cs_prev_q <= cs_sync_q[1];
      sclk_prev_q <= sclk_sync_q[1];
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic sclk_rise;

  assign cs_fall = cs_prev_q & ~cs_sync_q[1];
  assign cs_rise = ~cs_prev_q & cs_sync_q[1];
  assign sclk_fall = sclk_prev_q & ~sclk_sync_q[1];
  assign sclk_rise = ~sclk_prev_q & sclk_sync_q[1];

  // ----------------------------------------
  // control register
  // ----------------------------------------
  logic link_en_q;
  logic clear_q;
  logic wr_acc;

  assign wr_acc = psel & penable & pready & pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link_en_q <= `DDL_CTRL_RESET;
      clear_q <= 1'b0;
    end
    else if (clk_en)
    begin
      clear_q <= 1'b0;
      if (wr_acc && paddr == ADDR_W'(`DDL_OFF_CTRL))
      begin
        link_en_q <= pwdata[`DDL_CTRL_LINK_EN];
        clear_q <= pwdata[`DDL_CTRL_CLEAR];
      end
    end
  end

  // ----------------------------------------
  // serial word capture
  // ----------------------------------------
  ddl_link_state_t state_q;
  logic [15:0] shift_q;
  logic [4:0] bit_cnt_q;
  logic xfer;

  assign xfer = (state_q == LINK_SHIFT) &&
                ((sclk_rise && bit_cnt_q == WORD_BITS) ||
                 (cs_rise && bit_cnt_q != 5'h00));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= LINK_IDLE;
      shift_q <= 16'h0000;
      bit_cnt_q <= 5'h00;
    end
    else if (clk_en)
    begin
      case (state_q)
        LINK_IDLE:
        begin
          if (cs_fall && link_en_q)
          begin
            state_q <= LINK_SHIFT;
            shift_q <= 16'h0000;
            bit_cnt_q <= 5'h00;
          end
        end
        LINK_SHIFT:
        begin
          if (xfer)
            state_q <= cs_rise ? LINK_IDLE : LINK_DONE;
          else if (cs_rise)
            state_q <= LINK_IDLE;
          else if (sclk_fall && bit_cnt_q != WORD_BITS)
          begin
            shift_q <= {shift_q[14:0], sdi_sync_q[1]};
            bit_cnt_q <= bit_cnt_q + 5'h01;
          end
        end
        LINK_DONE:
        begin
          if (cs_rise)
            state_q <= LINK_IDLE;
        end
        default:
          state_q <= LINK_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // latches and mode bits
  // ----------------------------------------
  ddl_word_t word;
  logic [11:0] dbuf_q;
  logic [15:0] last_word_q;

  assign word = ddl_word_t'(shift_q);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dac_codes <= '0;
      dbuf_q <= 12'h000;
      fast_settle <= 1'b0;
      power_down <= 1'b0;
      last_word_q <= 16'h0000;
      update_pulse <= 1'b0;
    end
    else if (clk_en)
    begin
      update_pulse <= xfer;
      if (xfer)
      begin
        last_word_q <= shift_q;
        fast_settle <= word.speed_fast;
        power_down <= word.power_down;
        if (word.latch_a_sel)
        begin
          dac_codes.code_a <= word.code;
          dac_codes.code_b <= dbuf_q;
        end
        else if (!word.buffer_only)
        begin
          dac_codes.code_b <= word.code;
          dbuf_q <= word.code;
        end
        else
          dbuf_q <= word.code;
      end
      else if (clear_q)
      begin
        dac_codes <= '0;
        dbuf_q <= 12'h000;
      end
    end
  end

  // ----------------------------------------
  // settling timer
  // ----------------------------------------
  logic [7:0] settle_cnt_q;
  logic outputs_move;

  assign outputs_move = xfer & (word.latch_a_sel | ~word.buffer_only);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      settle_cnt_q <= 8'h00;
      settling <= 1'b0;
    end
    else if (clk_en)
    begin
      if (outputs_move)
      begin
        settle_cnt_q <= word.speed_fast ? FAST_CYC : SLOW_CYC;
        settling <= 1'b1;
      end
      else if (settle_cnt_q != 8'h00)
      begin
        settle_cnt_q <= settle_cnt_q - 8'h01;
        settling <= settle_cnt_q != 8'h01;
      end
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  logic [31:0] rdata_d;
  logic hit_d;

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    hit_d = 1'b1;
    case (paddr)
      ADDR_W'(`DDL_OFF_CTRL):
        rdata_d[`DDL_CTRL_LINK_EN] = link_en_q;
      ADDR_W'(`DDL_OFF_LATCH_A):
        rdata_d[11:0] = dac_codes.code_a;
      ADDR_W'(`DDL_OFF_LATCH_B):
        rdata_d[11:0] = dac_codes.code_b;
      ADDR_W'(`DDL_OFF_DBUF):
        rdata_d[11:0] = dbuf_q;
      ADDR_W'(`DDL_OFF_STATUS):
      begin
        rdata_d[`DDL_ST_FAST] = fast_settle;
        rdata_d[`DDL_ST_POWER_DOWN] = power_down;
        rdata_d[`DDL_ST_SETTLING] = settling;
        rdata_d[`DDL_ST_ACTIVE] = state_q == LINK_SHIFT;
        rdata_d[`DDL_ST_DONE] = state_q == LINK_DONE;
        rdata_d[`DDL_ST_COUNT_LSB +: 5] = bit_cnt_q;
      end
      ADDR_W'(`DDL_OFF_LAST_WORD):
        rdata_d[15:0] = last_word_q;
      default:
        hit_d = 1'b0;
    endcase
  end

  // answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_d;
      if (psel && !penable && !pwrite)
        prdata <= rdata_d;
    end
  end

endmodule

`default_nettype wire

// File: tb/ddl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ddl_checker
  import ddl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic chip_select_n,
  input wire ddl_codes_t dac_codes,
  input wire logic fast_settle,
  input wire logic power_down,
  input wire logic update_pulse
);
  // ----
  // port relations
  // ----
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_PREADY_SETUP:
    assert property (psel && !penable |=> pready) else $error("no answer");
  AST_PREADY_ONE:
    assert property (pready |=> !pready) else $error("pready too long");
  AST_ERR_READY:
    assert property (pslverr |-> pready) else $error("lone error");
  AST_UPD_ONE:
    assert property (update_pulse |=> !update_pulse) else $error("long pulse");
  AST_CODES_XFER:
    assert property ($changed(dac_codes) |-> update_pulse) else $error("stray code");
  AST_SPEED_XFER:
    assert property ($changed(fast_settle) |-> update_pulse) else $error("stray speed");
  AST_PD_XFER:
    assert property ($changed(power_down) |-> update_pulse) else $error("stray pd");
  AST_CS_IDLE:
    assert property (chip_select_n [*8] |-> !update_pulse) else $error("idle xfer");
endmodule
bind ddl_top ddl_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .chip_select_n(chip_select_n),
  .dac_codes(dac_codes), .fast_settle(fast_settle), .power_down(power_down),
  .update_pulse(update_pulse));
`default_nettype wire

// File: tb/ddl_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ddl_host_model
(
  output var logic chip_select_n,
  output var logic serial_clock,
  output var logic serial_data_in
);
  // ----
  // serial host
  // ----
  initial
  begin
    chip_select_n = 1'b1;
    serial_clock = 1'b1;
    serial_data_in = 1'b0;
  end
  task automatic send(input logic [15:0] w, input int n);
    #10;
    chip_select_n = 1'b0;
    #200;
    for (int i = 0; i < n; i++)
    begin
      serial_data_in = i < 16 ? w[15 - i] : ~serial_data_in;
      #100;
      serial_clock = 1'b0;
      #200;
      serial_clock = 1'b1;
      #100;
    end
    #400;
    chip_select_n = 1'b1;
    serial_data_in = ~serial_data_in;
    #400;
  endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ddl_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000, ea = 12'h000, eb = 12'h000, ebuf = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, s = 32'h624B, r;
  logic pready, pslverr, chip_select_n, serial_clock, serial_data_in;
  logic fast_settle, power_down, settling, update_pulse;
  ddl_codes_t dac_codes;
  logic [26:0] q[$];
  logic [26:0] e;
  int bad_count = 0, tests_run = 0, cyc = 0;
  always #25 pclk = ~pclk;
  ddl_top u_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chip_select_n(chip_select_n),
    .serial_clock(serial_clock), .serial_data_in(serial_data_in), .dac_codes(dac_codes),
    .fast_settle(fast_settle), .power_down(power_down), .settling(settling),
    .update_pulse(update_pulse));
  ddl_host_model u_host (.chip_select_n(chip_select_n), .serial_clock(serial_clock),
    .serial_data_in(serial_data_in));
  // ----
  // helpers
  // ----
  task fail(input string m);
    bad_count++;
    $display("mismatch %0t %s", $time, m);
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  function logic [31:0] xs();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    tests_run++;
    if (pready !== 1'b1)
      fail("no pready");
    if ((!w && prdata !== d) || pslverr !== er)
      fail("apb answer");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task word(input logic [15:0] w, input int n, input logic take);
    logic [15:0] v;
    v = n < 16 ? w >> (16 - n) : w;
    if (take && v[15])
    begin
      ea = v[11:0];
      eb = ebuf;
    end
    else if (take && !v[12])
    begin
      eb = v[11:0];
      ebuf = v[11:0];
    end
    else if (take)
      ebuf = v[11:0];
    if (take)
      q.push_back({ea, eb, v[14], v[13], v[15] | ~v[12]});
    u_host.send(w, n);
    repeat (12) @(posedge pclk);
  endtask
  // ----
  // result watcher and run
  // ----
  always @(posedge pclk)
    if (update_pulse === 1'b1)
    begin
      tests_run++;
      if (q.size() == 0)
        fail("unexpected transfer");
      else
      begin
        e = q.pop_front();
        if ({dac_codes, fast_settle, power_down} !== e[26:1])
          fail("latch state");
        if (e[0] && settling !== 1'b1)
          fail("no settling");
      end
    end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      conclude();
    end
  end
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h1, 1'b0);
    apb(1'b1, 12'h004, 32'hFFF, 1'b0);
    for (int i = 4; i < 16; i += 4)
      apb(1'b0, i[11:0], 32'h0, 1'b0);
    apb(1'b0, 12'h020, 32'h0, 1'b1);
    for (int i = 0; i < 10; i++)
    begin
      r = xs();
      word({i[0], i < 4, i > 3 && i < 8, i[1], r[11:0]}, 16, 1'b1);
    end
    apb(1'b0, 12'h004, {20'h0, ea}, 1'b0);
    r = xs();
    word(r[15:0], 12, 1'b1);
    word(r[31:16], 18, 1'b1);
    apb(1'b1, 12'h000, 32'h0, 1'b0);
    r = xs();
    word(r[15:0], 16, 1'b0);
    apb(1'b1, 12'h000, 32'h1, 1'b0);
    if (q.size() != 0)
      fail("missing transfer");
    conclude();
  end
endmodule
`default_nettype wire
